/* File: pkg/csei_consts.svh */
// constants for the comparator synchronizer and edge interrupt block
//
// What this block does
// - hysteresis only while hysteresis select is set
// - sync bit routes output through timer latch
// - latch captures on timer clock falling edge
// - prescaled timer clock drives latch when prescaling
// - timer advances on opposite, rising clock edge
// - comparator output offered as timer gate source
// - separate rising and falling edge detectors
// - enabled rising or falling edge sets flag
// - request needs on, enable, peripheral, global enables
// - only software clears the interrupt flag
// - edge during clear write leaves flag set
// - polarity or on toggle can raise flag
// - flag sets regardless of enable, peripheral, global enables; only the edge enables gate it
`ifndef CSEI_CONSTS_SVH
`define CSEI_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define CSEI_OFS_CTL0 3'h0
`define CSEI_OFS_CTL1 3'h1
`define CSEI_OFS_MIRROR 3'h2
`define CSEI_OFS_STATUS 3'h3
`define CSEI_OFS_CLEAR 3'h4
`define CSEI_OFS_ENABLE 3'h5
`define CSEI_OFS_INTCTL 3'h6

// ****************************************
// field positions
// ****************************************
`define CSEI_BIT_FLAG 0
`define CSEI_BIT_RISE 1
`define CSEI_BIT_FALL 2
`define CSEI_BIT_MIRROR 0
`define CSEI_BIT_GIE 7
`define CSEI_BIT_PERIPHERAL_IRQ_ENABLE 6
`define CSEI_BIT_RESULT 6

// ****************************************
// reset values and masks
// ****************************************
`define CSEI_RST_CTL0 8'h00
`define CSEI_RST_CTL1 8'h00
`define CSEI_RST_STATUS 3'h0
`define CSEI_RST_ENABLE 3'h0
`define CSEI_RST_INTCTL 2'h0
`define CSEI_CTL0_WMASK 8'hb7
`define CSEI_CTL1_WMASK 8'hf7

`endif

/* File: pkg/csei_pkg.sv */
// types of the comparator synchronizer and edge interrupt block
package csei_pkg;

    typedef struct packed {
        logic on;
        logic result;
        logic pinOe;
        logic polarity;
        logic rsvd3;
        logic speedSel;
        logic hysSel;
        logic syncSel;
    } csei_ctl0_t;

    typedef struct packed {
        logic posEdgeIrqEn;
        logic negEdgeIrqEn;
        logic [1:0] posInSel;
        logic rsvd3;
        logic [2:0] negInSel;
    } csei_ctl1_t;

    typedef struct packed {
        logic fall;
        logic rise;
        logic flag;
    } csei_evt_t;

endpackage : csei_pkg

/* File: src/csei_edge_det.sv */
// rising and falling edge detector for one same-domain level
`timescale 1ns/1ns
`default_nettype none

module csei_edge_det (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // level in, edge pulses out
    input wire logic level,
    output logic rise,
    output logic fall
);

    logic prev_r;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= level;
        end
    end

    assign rise = level & ~prev_r;
    assign fall = ~level & prev_r;

endmodule : csei_edge_det

`default_nettype wire

/* File: src/csei_top.sv */
// comparator output synchronizer, edge detection and interrupt flag logic
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "csei_consts.svh"

module csei_top #(
    parameter int ADDR_W = 3
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    // analog comparator core
    input wire logic cmpRawOut,
    output logic cmpOn,
    output logic hysteresisSelect,
    output logic speedPowerSelect,
    output logic [1:0] positiveInputSelect,
    output logic [2:0] negativeInputSelect,
    // timer1 side
    input wire logic tmr1SrcClk,
    input wire logic tmr1PrescClk,
    input wire logic tmr1PrescUse,
    output logic tmr1Tick,
    output logic tmr1GateSrc,
    // comparator output pin
    output logic cmpPinOut,
    output logic cmpPinOe_n,
    // interrupt
    output logic cmpIrq
);

    // ****************************************
    // registers
    // ****************************************
    csei_pkg::csei_ctl0_t ctl0_r;
    csei_pkg::csei_ctl1_t ctl1_r;
    csei_pkg::csei_evt_t status_r;
    csei_pkg::csei_evt_t status_nxt;
    csei_pkg::csei_evt_t enable_r;
    logic [1:0] intCtl_r;
    logic [7:0] rdData_nxt;

    // ****************************************
    // input synchronizers
    // ****************************************
    // bit 0 comparator, bit 1 timer source clock, bit 2 prescaled clock
    logic [2:0] syncMeta_r;
    logic [2:0] syncStab_r;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            syncMeta_r <= 3'h0;
            syncStab_r <= 3'h0;
        end else begin
            syncMeta_r <= {tmr1PrescClk, tmr1SrcClk, cmpRawOut};
            syncStab_r <= syncMeta_r;
        end
    end

    // ****************************************
    // polarity and output value
    // ****************************************
    // a switched-off core reads as low, so toggling on or polarity moves the value
    logic cmpVal;
    assign cmpVal = (ctl0_r.on & syncStab_r[0]) ^ ctl0_r.polarity;

    // ****************************************
    // timer clock select and edges
    // ****************************************
    logic tmrClkSel;
    logic clkRise;
    logic clkFall;
    assign tmrClkSel = tmr1PrescUse ? syncStab_r[2] : syncStab_r[1];

    csei_edge_det u_clk_edge (
        .core_clk(core_clk),
        .srst(srst),
        .level(tmrClkSel),
        .rise(clkRise),
        .fall(clkFall)
    );

    // ****************************************
    // synchronizing latch
    // ****************************************
    logic latch_r;
    logic selOut;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            latch_r <= 1'b0;
        end else if (clkFall) begin
            latch_r <= cmpVal;
        end
    end

    assign selOut = ctl0_r.syncSel ? latch_r : cmpVal;

    // ****************************************
    // timer1 facing outputs
    // ****************************************
    // counting on the rising edge keeps the count away from the latch update
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tmr1Tick <= 1'b0;
            tmr1GateSrc <= 1'b0;
        end else begin
            tmr1Tick <= clkRise;
            tmr1GateSrc <= selOut;
        end
    end

    // ****************************************
    // output edge detectors
    // ****************************************
    logic outRise;
    logic outFall;
    logic flagSet;

    csei_edge_det u_out_edge (
        .core_clk(core_clk),
        .srst(srst),
        .level(selOut),
        .rise(outRise),
        .fall(outFall)
    );

    // only the edge enables take part here, no request, peripheral or global enable
    assign flagSet = (outRise & ctl1_r.posEdgeIrqEn) | (outFall & ctl1_r.negEdgeIrqEn);

    // ****************************************
    // register writes
    // ****************************************
    logic wrCtl0;
    logic wrCtl1;
    logic wrClear;
    logic wrEnable;
    logic wrIntCtl;
    assign wrCtl0 = regWrStb && (regAddr == `CSEI_OFS_CTL0);
    assign wrCtl1 = regWrStb && (regAddr == `CSEI_OFS_CTL1);
    assign wrClear = regWrStb && (regAddr == `CSEI_OFS_CLEAR);
    assign wrEnable = regWrStb && (regAddr == `CSEI_OFS_ENABLE);
    assign wrIntCtl = regWrStb && (regAddr == `CSEI_OFS_INTCTL);

    // result bit is read-only and tracks the selected output
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctl0_r <= `CSEI_RST_CTL0;
        end else begin
            if (wrCtl0) begin
                ctl0_r <= regWrData & `CSEI_CTL0_WMASK;
            end else begin
                ctl0_r.result <= 1'b0;
            end
            ctl0_r.result <= selOut;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctl1_r <= `CSEI_RST_CTL1;
        end else if (wrCtl1) begin
            ctl1_r <= regWrData & `CSEI_CTL1_WMASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            enable_r <= `CSEI_RST_ENABLE;
        end else if (wrEnable) begin
            enable_r <= regWrData[2:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            intCtl_r <= `CSEI_RST_INTCTL;
        end else if (wrIntCtl) begin
            intCtl_r <= {regWrData[`CSEI_BIT_GIE], regWrData[`CSEI_BIT_PERIPHERAL_IRQ_ENABLE]};
        end
    end

    // ****************************************
    // sticky status
    // ****************************************
    // hardware only sets; a write of one to the clear register drops a bit
    always_comb begin
        status_nxt = status_r;
        if (wrClear) begin
            status_nxt = status_r & ~csei_pkg::csei_evt_t'(regWrData[2:0]);
        end
        status_nxt.flag = status_nxt.flag | flagSet;
        status_nxt.rise = status_nxt.rise | outRise;
        status_nxt.fall = status_nxt.fall | outFall;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            status_r <= `CSEI_RST_STATUS;
        end else begin
            status_r <= status_nxt;
        end
    end

    // ****************************************
    // interrupt request
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cmpIrq <= 1'b0;
        end else begin
            cmpIrq <= ctl0_r.on & (|(status_r & enable_r)) & intCtl_r[1] & intCtl_r[0];
        end
    end

    // ****************************************
    // core and pin outputs
    // ****************************************
    assign cmpOn = ctl0_r.on;
    assign hysteresisSelect = ctl0_r.hysSel;
    assign speedPowerSelect = ctl0_r.speedSel;
    assign positiveInputSelect = ctl1_r.posInSel;
    assign negativeInputSelect = ctl1_r.negInSel;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cmpPinOut <= 1'b0;
            cmpPinOe_n <= 1'b1;
        end else begin
            cmpPinOut <= selOut;
            cmpPinOe_n <= ~ctl0_r.pinOe;
        end
    end

    // ****************************************
    // register reads
    // ****************************************
    always_comb begin
        rdData_nxt = 8'h00;
        unique case (regAddr)
            `CSEI_OFS_CTL0: rdData_nxt = ctl0_r;
            `CSEI_OFS_CTL1: rdData_nxt = ctl1_r;
            `CSEI_OFS_MIRROR: rdData_nxt[`CSEI_BIT_MIRROR] = ctl0_r.result;
            `CSEI_OFS_STATUS: rdData_nxt[2:0] = status_r;
            `CSEI_OFS_ENABLE: rdData_nxt[2:0] = enable_r;
            `CSEI_OFS_INTCTL: begin
                rdData_nxt[`CSEI_BIT_GIE] = intCtl_r[1];
                rdData_nxt[`CSEI_BIT_PERIPHERAL_IRQ_ENABLE] = intCtl_r[0];
            end
            default: rdData_nxt = 8'h00;
        endcase
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (srst) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= regRdStb ? rdData_nxt : 8'h00;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    sequence rise_armed_s;
        outRise && ctl1_r.posEdgeIrqEn;
    endsequence

    sequence fall_armed_s;
        outFall && ctl1_r.negEdgeIrqEn;
    endsequence

    hys_write_a: assert property (wrCtl0 |=> hysteresisSelect == $past(regWrData[1]))
        else $error("hysteresis select not taken from write");

    sync_hold_a: assert property ((ctl0_r.syncSel && !clkFall) |=> $stable(latch_r))
        else $error("latch moved without a timer falling edge");

    fall_capture_a: assert property (clkFall |=> latch_r == $past(cmpVal))
        else $error("latch missed falling edge capture");

    presc_pick_a: assert property ((tmr1PrescUse && $past(tmr1PrescUse) && $fell(syncStab_r[2])) |-> clkFall)
        else $error("prescaled clock edge not used");

    tick_rise_a: assert property (clkRise |=> tmr1Tick ##1 !tmr1Tick)
        else $error("timer tick not one pulse after rising edge");

    gate_bypass_a: assert property (!ctl0_r.syncSel |=> tmr1GateSrc == $past(cmpVal))
        else $error("unsynchronized gate does not follow output");

    flag_set_a: assert property ((rise_armed_s or fall_armed_s) |=> status_r.flag)
        else $error("enabled edge did not set flag");

    flag_clear_a: assert property ($fell(status_r.flag) |-> $past(wrClear && regWrData[0]))
        else $error("flag cleared without software write");

    irq_gate_a: assert property (cmpIrq |-> $past(ctl0_r.on && intCtl_r == 2'h3 && (|(status_r & enable_r))))
        else $error("interrupt without on and enables");

    pol_toggle_a: assert property (($changed(ctl0_r.polarity) && !ctl0_r.syncSel && !$changed(ctl0_r.on)
        && ctl1_r.posEdgeIrqEn && ctl1_r.negEdgeIrqEn && $stable(syncStab_r[0])) |=> status_r.flag)
        else $error("polarity toggle did not set flag");

endmodule : csei_top

`default_nettype wire

/* File: testbench/csei_partner.sv */
// comparator core and timer1 clock source model
`timescale 1ns/1ns
`default_nettype none

module csei_partner (
    // clock
    input wire logic core_clk,
    // stimulus from the bench
    input wire logic level,
    input wire logic run,
    // towards the block
    output logic cmpRawOut,
    output logic tmr1SrcClk,
    output logic tmr1PrescClk
);
    logic [6:0] cnt_r = 7'h00;
    logic raw_r = 1'b0;

    // timer clocks stand still while run is low, so every burst starts from a known phase
    always_ff @(posedge core_clk) begin
        if (run) begin
            cnt_r <= cnt_r + 7'h01;
        end
    end

    assign tmr1SrcClk = cnt_r[3];
    // divide-by-four prescaler after the source clock
    assign tmr1PrescClk = cnt_r[5];

    // the core answers a cycle late, standing in for its response time
    always_ff @(posedge core_clk) begin
        raw_r <= level;
    end

    assign cmpRawOut = raw_r;
endmodule : csei_partner

`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the comparator edge interrupt block
`timescale 1ns/1ns
`default_nettype none
`include "csei_consts.svh"

module tb_top;
    logic core_clk, srst, regWrStb, regRdStb, cmpRawOut, tmr1SrcClk, tmr1PrescClk, tmr1PrescUse;
    logic [2:0] regAddr;
    logic [7:0] regWrData, regRdData, d, r;
    logic cmpOn, hysteresisSelect, speedPowerSelect, tmr1Tick, tmr1GateSrc, cmpPinOut, cmpPinOe_n, cmpIrq;
    logic level, run;
    logic [1:0] positiveInputSelect;
    logic [2:0] negativeInputSelect;
    int n_fail, check_count, seed, cyc, ticks, on, pol, posEn, negEn, val, st;

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    csei_top csei_top_inst (
        .core_clk, .srst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
        .cmpRawOut, .cmpOn, .hysteresisSelect, .speedPowerSelect, .positiveInputSelect,
        .negativeInputSelect, .tmr1SrcClk, .tmr1PrescClk, .tmr1PrescUse, .tmr1Tick,
        .tmr1GateSrc, .cmpPinOut, .cmpPinOe_n, .cmpIrq
    );

    csei_partner csei_partner_inst (
        .core_clk, .level, .run, .cmpRawOut, .tmr1SrcClk, .tmr1PrescClk
    );

    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task wr(input logic [2:0] a, input logic [7:0] v);
        regAddr <= a;
        regWrData <= v;
        regWrStb <= 1'b1;
        @(posedge core_clk);
        regWrStb <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    task rchk(input logic [2:0] a, input logic [7:0] e);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge core_clk);
        regRdStb <= 1'b0;
        #1 d = regRdData;
        chk(d, e);
        @(posedge core_clk);
    endtask : rchk

    // reference model of the output value, the sticky edge bits and the flag
    task upd;
        int nv;
        nv = (on & level) ^ pol;
        if (nv > val) st = st | 2 | posEn;
        if (nv < val) st = st | 4 | negEn;
        val = nv;
    endtask : upd

    always @(posedge core_clk) begin
        cyc++;
        if (tmr1Tick === 1'b1) ticks++;
        if (cyc == 5000) begin
            n_fail++;
            report_and_stop();
        end
    end

    initial begin
        srst = 1'b1;
        regAddr = 3'h0;
        regWrData = 8'h00;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        tmr1PrescUse = 1'b0;
        level = 1'b0;
        run = 1'b0;
        seed = 85268;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        for (int a = 0; a < 8; a++) begin
            rchk(a[2:0], 8'h00);
        end
        chk({7'h0, cmpPinOe_n}, 8'h01);
        $display("test reset done");
        r = 8'($random(seed));
        wr(`CSEI_OFS_CTL1, r);
        wr(3'h7, 8'hff);
        rchk(`CSEI_OFS_CTL1, r & `CSEI_CTL1_WMASK);
        rchk(3'h7, 8'h00);
        chk({3'h0, positiveInputSelect, negativeInputSelect}, {3'h0, r[5:4], r[2:0]});
        $display("test registers done");
        wr(`CSEI_OFS_CTL0, 8'ha6);
        on = 1;
        for (int i = 0; i < 12; i++) begin
            r = 8'($random(seed));
            wr(`CSEI_OFS_CTL1, r & 8'hc0);
            posEn = r[7];
            negEn = r[6];
            level <= r[0];
            repeat (6) @(posedge core_clk);
            upd();
            rchk(`CSEI_OFS_STATUS, st[7:0]);
            rchk(`CSEI_OFS_MIRROR, val[7:0]);
            chk({6'h0, tmr1GateSrc, cmpPinOut}, {6'h0, val[0], val[0]});
            if (i % 3 == 2) begin
                wr(`CSEI_OFS_CLEAR, 8'h07);
                st = 0;
            end
        end
        rchk(`CSEI_OFS_CTL0, {1'b1, val[0], 6'h26});
        chk({4'h0, cmpOn, speedPowerSelect, hysteresisSelect, cmpPinOe_n}, 8'h0e);
        $display("test direct edges done");
        wr(`CSEI_OFS_CTL1, 8'hc0);
        posEn = 1;
        negEn = 1;
        level <= 1'b0;
        repeat (6) @(posedge core_clk);
        wr(`CSEI_OFS_CLEAR, 8'h07);
        st = 0;
        val = 0;
        // polarity flip with the comparator off, clear written in the very next cycle
        regAddr <= `CSEI_OFS_CTL0;
        regWrData <= 8'h10;
        regWrStb <= 1'b1;
        @(posedge core_clk);
        regAddr <= `CSEI_OFS_CLEAR;
        regWrData <= 8'h01;
        @(posedge core_clk);
        regWrStb <= 1'b0;
        @(posedge core_clk);
        on = 0;
        pol = 1;
        upd();
        rchk(`CSEI_OFS_STATUS, st[7:0]);
        wr(`CSEI_OFS_CLEAR, 8'h01);
        repeat (4) @(posedge core_clk);
        rchk(`CSEI_OFS_STATUS, 8'h02);
        $display("test set over clear done");
        wr(`CSEI_OFS_CTL0, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(`CSEI_OFS_ENABLE, {7'h0, i != 0});
            wr(`CSEI_OFS_INTCTL, i == 1 ? 8'h80 : i == 2 ? 8'h40 : 8'hc0);
            wr(`CSEI_OFS_CTL0, {i != 3, 7'h00});
            repeat (2) @(posedge core_clk);
            chk({7'h0, cmpIrq}, {7'h0, i == 4});
        end
        $display("test irq gating done");
        wr(`CSEI_OFS_CLEAR, 8'h07);
        st = 0;
        on = 1;
        pol = 0;
        val = 0;
        wr(`CSEI_OFS_CTL0, 8'ha1);
        level <= 1'b1;
        repeat (10) @(posedge core_clk);
        chk({7'h0, tmr1GateSrc}, 8'h00);
        rchk(`CSEI_OFS_STATUS, 8'h00);
        ticks = 0;
        run <= 1'b1;
        repeat (64) @(posedge core_clk);
        run <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk({7'h0, tmr1GateSrc}, 8'h01);
        upd();
        rchk(`CSEI_OFS_STATUS, st[7:0]);
        chk(ticks[7:0], 8'h04);
        tmr1PrescUse <= 1'b1;
        ticks = 0;
        run <= 1'b1;
        repeat (64) @(posedge core_clk);
        run <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk(ticks[7:0], 8'h01);
        $display("test sync path done");
        report_and_stop();
    end
endmodule : tb_top

`default_nettype wire
